// file: core/mss_core.sv
// Purpose: Byte-wide serial port, master or slave, behind an Avalon-MM slave
// Assumes: Pin inputs are asynchronous; three-state wiring is outside
// Notes: Master samples MISO after the synchroniser, so fast rates need a slow slave path
`timescale 1ns/10ps
`default_nettype none
module mss_core
    import mss_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Core interrupt side
    input wire logic global_irq_en,
    input wire logic irq_vector_taken,
    output logic irq,
    // Pins
    input wire mss_pin_in_t pin_in,
    input wire mss_dir_t pin_dir,
    output mss_pin_out_t pin_out
);
    logic [7:0] control;
    logic done_flag;
    logic coll_flag;
    logic dbl;
    logic [7:0] rx_buf;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic dout;
    logic [3:0] cnt;
    logic m_busy;
    logic sck_lvl;
    logic arm_done;
    logic arm_coll;
    mss_pin_in_t pin_s;
    logic sck_d;
    logic tick;

    logic port_enable_bit;
    logic master_select_bit;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic lsb_first;
    logic acc;
    logic wr_data;
    logic data_acc;
    logic busy;
    logic fault;
    logic slave_act;
    logic ev;
    logic sample_ev;
    logic shift_ev;
    logic done;
    logic din;
    logic start;

    assign port_enable_bit = control[MSS_CTL_PORT_EN];
    assign master_select_bit = control[MSS_CTL_MASTER];
    assign clock_polarity_bit = control[MSS_CTL_POL];
    assign clock_phase_bit = control[MSS_CTL_PHASE];
    assign lsb_first = control[MSS_CTL_ORDER];

    // Request is taken at the edge where waitrequest is seen low
    assign acc = (read || write) && !waitrequest;
    assign wr_data = acc && write && byteenable[0] && address == MSS_ADDR_DATA;
    assign data_acc = acc && address == MSS_ADDR_DATA && (read || byteenable[0]);
    assign busy = m_busy || cnt != 4'h0;

    assign fault = port_enable_bit && master_select_bit && !pin_dir.ss && !pin_s.ss_n;
    assign slave_act = port_enable_bit && !master_select_bit && !pin_s.ss_n;
    // Each SCK edge, generated or received, drives the same shifter;
    // slave edges only count once SCK has settled at its idle level
    assign ev = m_busy ? tick : (slave_act && pin_s.sck != sck_d && (cnt != 4'h0 || sck_d == clock_polarity_bit));
    assign sample_ev = ev && (cnt[0] == clock_phase_bit);
    assign shift_ev = ev && (cnt[0] != clock_phase_bit);
    assign done = ev && cnt == MSS_EDGE_LAST;
    assign din = master_select_bit ? pin_s.miso : pin_s.mosi;
    assign start = wr_data && !busy && port_enable_bit && master_select_bit && !fault;

    always_comb begin
        next_sh = sh;
        if (sample_ev) begin
            next_sh = lsb_first ? {din, sh[7:1]} : {sh[6:0], din};
        end
    end

    mss_sync #(.W(4), .INIT(4'h1)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(pin_in),
        .q(pin_s)
    );

    // Rate bits only reach the generator, which runs in master mode only
    mss_rate_gen u_rate (
        .clk(clk),
        .reset_n(reset_n),
        .run(m_busy),
        .sel({dbl, control[MSS_CTL_RATE_HI], control[MSS_CTL_RATE_LO]}),
        .tick(tick)
    );

    // Bus handshake: one wait cycle, then the answer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else if (waitrequest && (read || write)) begin
            waitrequest <= 1'b0;
            readdata <= 32'h0;
            if (read) begin
                case (address)
                    MSS_ADDR_CONTROL: readdata[7:0] <= control;
                    MSS_ADDR_STATUS: readdata[7:0] <= {done_flag, coll_flag, 5'h00, dbl};
                    MSS_ADDR_DATA: readdata[7:0] <= rx_buf;
                    default: readdata <= 32'h0;
                endcase
            end
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // Control register; a mode fault wins over a same-cycle write
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            control <= MSS_CONTROL_RESET;
            dbl <= MSS_STATUS_RESET[MSS_STS_DBL];
        end else begin
            if (acc && write && byteenable[0] && address == MSS_ADDR_CONTROL) begin
                control <= writedata[7:0];
            end
            if (acc && write && byteenable[0] && address == MSS_ADDR_STATUS) begin
                dbl <= writedata[MSS_STS_DBL];
            end
            if (fault) begin
                control[MSS_CTL_MASTER] <= 1'b0;
            end
        end
    end

    // Flag arming by a status read, consumed by the next data access
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arm_done <= 1'b0;
            arm_coll <= 1'b0;
        end else if (acc && read && address == MSS_ADDR_STATUS) begin
            arm_done <= readdata[MSS_STS_DONE] || readdata[MSS_STS_COLL];
            arm_coll <= readdata[MSS_STS_COLL];
        end else if (data_acc) begin
            arm_done <= 1'b0;
            arm_coll <= 1'b0;
        end
    end

    // Done flag: a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_flag <= MSS_STATUS_RESET[MSS_STS_DONE];
        end else if (done || fault) begin
            done_flag <= 1'b1;
        end else if (irq_vector_taken) begin
            done_flag <= 1'b0;
        end else if (data_acc && arm_done) begin
            done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            coll_flag <= MSS_STATUS_RESET[MSS_STS_COLL];
        end else if (wr_data && busy) begin
            coll_flag <= 1'b1;
        end else if (data_acc && arm_coll) begin
            coll_flag <= 1'b0;
        end
    end

    // Master run flag and edge counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            m_busy <= 1'b0;
            cnt <= 4'h0;
            sck_d <= 1'b0;
        end else begin
            sck_d <= pin_s.sck;
            if (!port_enable_bit || fault) begin
                m_busy <= 1'b0;
                cnt <= 4'h0;
            end else if (!master_select_bit && pin_s.ss_n) begin
                m_busy <= 1'b0;
                cnt <= 4'h0;
            end else begin
                if (start) begin
                    m_busy <= 1'b1;
                end else if (done && m_busy) begin
                    m_busy <= 1'b0;
                end
                if (ev) begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end

    // Master SCK level toggles on every generated edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_lvl <= 1'b0;
        end else if (!m_busy) begin
            sck_lvl <= clock_polarity_bit;
        end else if (tick) begin
            sck_lvl <= !sck_lvl;
        end
    end

    // Shifter; writes during a transfer never reach it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sh <= MSS_DATA_RESET;
            dout <= 1'b0;
        end else if (wr_data && !busy) begin
            sh <= writedata[7:0];
            dout <= lsb_first ? writedata[0] : writedata[7];
        end else begin
            sh <= next_sh;
            if (shift_ev) begin
                dout <= lsb_first ? sh[0] : sh[7];
            end
        end
    end

    // Receive buffer holds until the next full byte replaces it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_buf <= MSS_DATA_RESET;
        end else if (done) begin
            rx_buf <= next_sh;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= control[MSS_CTL_IRQ_EN] && done_flag && global_irq_en;
        end
    end

    // Pin drivers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_out <= '0;
        end else begin
            pin_out.sck <= sck_lvl;
            pin_out.mosi <= dout;
            pin_out.miso <= dout;
            pin_out.ss_n <= pin_dir.ss_level;
            pin_out.sck_oe <= port_enable_bit && master_select_bit && pin_dir.sck;
            pin_out.mosi_oe <= port_enable_bit && master_select_bit && pin_dir.mosi;
            pin_out.miso_oe <= slave_act && pin_dir.miso;
            pin_out.ss_oe <= pin_dir.ss && !(port_enable_bit && !master_select_bit);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_fault;
        fault |=> !master_select_bit && done_flag;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not handled");

    property p_fault_pins;
        fault ##1 1'b1 |=> !pin_out.sck_oe && !pin_out.mosi_oe;
    endproperty
    a_fault_pins: assert property (p_fault_pins) else $error("pins driven after fault");

    property p_ss_out;
        port_enable_bit && master_select_bit && pin_dir.ss |=> pin_out.ss_oe && pin_out.ss_n == $past(pin_dir.ss_level);
    endproperty
    a_ss_out: assert property (p_ss_out) else $error("select not a general output");

    property p_slave_pins;
        port_enable_bit && !master_select_bit |=> !pin_out.sck_oe && !pin_out.mosi_oe && !pin_out.ss_oe;
    endproperty
    a_slave_pins: assert property (p_slave_pins) else $error("slave drives an input pin");

    property p_deselect;
        port_enable_bit && !master_select_bit && pin_s.ss_n |=> cnt == 4'h0 && !m_busy;
    endproperty
    a_deselect: assert property (p_deselect) else $error("serial logic not reset");

    property p_disabled;
        !port_enable_bit |=> !busy;
    endproperty
    a_disabled: assert property (p_disabled) else $error("activity while disabled");

    property p_irq;
        control[MSS_CTL_IRQ_EN] && done_flag && global_irq_en ##1 control[MSS_CTL_IRQ_EN] |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_coll;
        wr_data && busy |=> coll_flag && ($stable(sh) || $past(sample_ev));
    endproperty
    a_coll: assert property (p_coll) else $error("collision not flagged");

    property p_fast;
        m_busy && tick && !done && {dbl, control[1:0]} == 3'h4 |=> tick;
    endproperty
    a_fast: assert property (p_fast) else $error("double rate period wrong");

    property p_done;
        done |=> done_flag && rx_buf == $past(next_sh) && !m_busy;
    endproperty
    a_done: assert property (p_done) else $error("byte completion wrong");

    property p_stop;
        done && m_busy |=> ##[1:3] pin_out.sck == clock_polarity_bit;
    endproperty
    a_stop: assert property (p_stop) else $error("SCK not idle after byte");
endmodule
`default_nettype wire

// file: core/mss_pkg.sv
// Purpose: Shared constants and carriers of the byte-wide serial port
// Assumes: Register byte address is four times the register index
// Notes: Data register index is placed right after the status index
package mss_pkg;
    localparam logic [7:0] MSS_IDX_CONTROL = 8'h0d;
    localparam logic [7:0] MSS_IDX_STATUS = 8'h0e;
    localparam logic [7:0] MSS_IDX_DATA = 8'h0f;
    localparam logic [7:0] MSS_ADDR_CONTROL = {MSS_IDX_CONTROL[5:0], 2'h0};
    localparam logic [7:0] MSS_ADDR_STATUS = {MSS_IDX_STATUS[5:0], 2'h0};
    localparam logic [7:0] MSS_ADDR_DATA = {MSS_IDX_DATA[5:0], 2'h0};

    // Control field positions
    localparam int MSS_CTL_IRQ_EN = 7;
    localparam int MSS_CTL_PORT_EN = 6;
    localparam int MSS_CTL_ORDER = 5;
    localparam int MSS_CTL_MASTER = 4;
    localparam int MSS_CTL_POL = 3;
    localparam int MSS_CTL_PHASE = 2;
    localparam int MSS_CTL_RATE_HI = 1;
    localparam int MSS_CTL_RATE_LO = 0;
    // Status field positions
    localparam int MSS_STS_DONE = 7;
    localparam int MSS_STS_COLL = 6;
    localparam int MSS_STS_DBL = 0;

    localparam logic [7:0] MSS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MSS_STATUS_RESET = 8'h00;
    localparam logic [7:0] MSS_DATA_RESET = 8'h00;
    localparam logic [3:0] MSS_EDGE_LAST = 4'hf;

    // Half SCK period in system clocks, indexed by {double, rate_hi, rate_lo}
    localparam logic [6:0] MSS_HALF_PERIOD [8] = '{
        7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20};

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } mss_pin_in_t;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
        logic ss_n;
        logic ss_oe;
    } mss_pin_out_t;

    // Software pin directions (1 = output) and general output level of select
    typedef struct packed {
        logic mosi;
        logic miso;
        logic sck;
        logic ss;
        logic ss_level;
    } mss_dir_t;
endpackage

// file: core/mss_rate_gen.sv
// Purpose: SCK half-period tick generator for master mode
// Assumes: Runs only while a master transfer is in progress
// Notes: First tick comes one half period after run rises
`timescale 1ns/10ps
`default_nettype none
module mss_rate_gen
    import mss_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic run,
    input wire logic [2:0] sel,
    // Half-period strobe
    output logic tick
);
    logic [6:0] count;
    logic [6:0] half;

    assign half = MSS_HALF_PERIOD[sel];

    always_ff @(posedge clk) begin
        if (!reset_n || !run) begin
            count <= 7'h00;
            tick <= 1'b0;
        end else if (count == half - 7'h01) begin
            count <= 7'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 7'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: core/mss_sync.sv
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: Output moves only once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module mss_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q <= INIT;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/mss_peer.sv
// Purpose: Behavioural serial peripheral facing the port in master mode
// Assumes: Format inputs are settled before select falls
// Notes: A deselected data line shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
module mss_peer (
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso,
    // Format and data
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit,
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic out_bit = 1'b0;
    int k = 0;
    // Rises on the sample edge in every format
    wire logic phase_clk = sck ^ clock_polarity_bit ^ clock_phase_bit;

    function automatic logic pick(input int i);
        return lsb_first ? tx_byte[i] : tx_byte[7 - i];
    endfunction

    // Simulator must not settle a released line to a lucky value
    assign miso = sel_n ? ~out_bit : out_bit;

    always @(negedge sel_n) begin
        k = clock_phase_bit ? 0 : 1;
        if (!clock_phase_bit) out_bit = pick(0);
    end

    always @(posedge phase_clk) begin
        if (!sel_n) rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
    end

    always @(negedge phase_clk) begin
        if (!sel_n && k < 8) begin
            out_bit = pick(k);
            k = k + 1;
        end
    end
endmodule
`default_nettype wire

// file: tb/spi_master_slave_port_test.sv
// Purpose: Self-checking bench of the serial port over its register bus
// Assumes: Peer model in master mode, bench drives pins in slave mode
// Notes: Master transfer tests use the slowest rate so MISO clears the synchroniser; the rate sweep runs all eight rates
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port_test;
    import mss_pkg::*;
    logic clk, reset_n, read, write, global_irq_en, irq_vector_taken;
    logic [7:0] address;
    logic [31:0] writedata, readdata;
    logic waitrequest, irq;
    mss_dir_t pin_dir;
    mss_pin_in_t pin_in;
    mss_pin_out_t pin_out;
    logic tb_sck, tb_mosi, tb_ss_n, psel_n, p_clock_polarity_bit, p_clock_phase_bit, p_lsb, p_miso;
    logic [7:0] p_tx, p_rx, st, got;
    int failures = 0;
    int check_count = 0;
    int h;
    int divs [8] = '{4, 16, 64, 128, 2, 8, 32, 64};

    // Wire level from whoever drives each pin
    assign pin_in = {pin_out.sck_oe ? pin_out.sck : tb_sck, pin_out.mosi_oe ? pin_out.mosi : tb_mosi,
                     pin_out.miso_oe ? pin_out.miso : p_miso, pin_out.ss_oe ? pin_out.ss_n : tb_ss_n};

    mss_core DUT (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .byteenable(4'h1), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .global_irq_en(global_irq_en), .irq_vector_taken(irq_vector_taken), .irq(irq),
        .pin_in(pin_in), .pin_dir(pin_dir), .pin_out(pin_out));

    mss_peer peer (.sck(pin_in.sck), .mosi(pin_in.mosi), .sel_n(psel_n), .miso(p_miso), .clock_polarity_bit(p_clock_polarity_bit),
        .clock_phase_bit(p_clock_phase_bit), .lsb_first(p_lsb), .tx_byte(p_tx), .rx_byte(p_rx));

    always #5 clk = ~clk;

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Request holds until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h000000, d};
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            failures++;
            wrap_up();
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    task automatic poll(output logic [7:0] s);
        int n;
        n = 0;
        do begin
            bus(1'b0, MSS_ADDR_STATUS, 8'h00, s);
            n++;
        end while (s[7] !== 1'b1 && n < 1000);
        if (s[7] !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic m_xfer(input logic [7:0] ctl, input logic [7:0] tx, input logic coll);
        logic [7:0] s;
        wr(MSS_ADDR_CONTROL, ctl);
        p_clock_polarity_bit <= ctl[3];
        p_clock_phase_bit <= ctl[2];
        p_lsb <= ctl[5];
        p_tx <= ~tx;
        // Idle SCK level lags the control write; select the peer only once it settles
        repeat (2) @(posedge clk);
        psel_n <= 1'b0;
        wr(MSS_ADDR_DATA, tx);
        if (coll) wr(MSS_ADDR_DATA, ~tx);
        poll(s);
        chk(s, {1'b1, coll, 6'h00});
        rd(MSS_ADDR_DATA, ~tx);
        rd(MSS_ADDR_STATUS, 8'h00);
        chk(p_rx, tx);
        chk({7'h00, pin_out.sck}, {7'h00, ctl[3]});
        psel_n <= 1'b1;
    endtask

    task automatic half_period(output int n);
        logic s;
        int w;
        w = 0;
        s = pin_out.sck;
        while (pin_out.sck === s && w < 400) begin
            @(posedge clk);
            w++;
        end
        s = pin_out.sck;
        n = 0;
        while (pin_out.sck === s && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Bench as external master, mode 0, MSB first
    task automatic ext_frame(input logic [7:0] m, input int nb, input logic sel, output logic [7:0] q);
        q = 8'h00;
        tb_ss_n <= ~sel;
        repeat (8) @(posedge clk);
        for (int i = 7; i > 7 - nb; i--) begin
            tb_mosi <= m[i];
            repeat (8) @(posedge clk);
            tb_sck <= 1'b1;
            repeat (8) @(posedge clk);
            q = {q[6:0], pin_in.miso};
            tb_sck <= 1'b0;
        end
        repeat (8) @(posedge clk);
        tb_ss_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {read, write, global_irq_en, irq_vector_taken} = 4'h0;
        address = 8'h00;
        writedata = 32'h00000000;
        pin_dir = 5'b10110;
        {tb_sck, tb_mosi, tb_ss_n, psel_n, p_clock_polarity_bit, p_clock_phase_bit, p_lsb} = 7'b0011000;
        p_tx = 8'h00;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd(MSS_ADDR_CONTROL, 8'h00);
        rd(MSS_ADDR_STATUS, 8'h00);
        rd(8'h00, 8'h00);
        wr(MSS_ADDR_STATUS, 8'hff);
        rd(MSS_ADDR_STATUS, 8'h01);
        wr(MSS_ADDR_STATUS, 8'h00);
        for (int i = 0; i < 8; i++) m_xfer({2'b01, i[2], 1'b1, i[0], i[1], 2'b11}, 8'(8'h1d + i * 37), 1'b0);
        chk({6'h00, pin_out.ss_oe, pin_out.ss_n}, 8'h02);
        rd(MSS_ADDR_CONTROL, 8'h7f);
        m_xfer(8'h53, 8'ha5, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(MSS_ADDR_STATUS, {7'h00, i[2]});
            wr(MSS_ADDR_CONTROL, {6'b010100, i[1:0]});
            wr(MSS_ADDR_DATA, 8'h00);
            half_period(h);
            chk(8'(h), 8'(divs[i] / 2));
            poll(st);
            bus(1'b0, MSS_ADDR_DATA, 8'h00, st);
        end
        wr(MSS_ADDR_STATUS, 8'h00);
        wr(MSS_ADDR_CONTROL, 8'h13);
        wr(MSS_ADDR_DATA, 8'h77);
        repeat (300) @(posedge clk);
        chk({7'h00, pin_out.sck_oe}, 8'h00);
        rd(MSS_ADDR_STATUS, 8'h00);
        pin_dir <= 5'b10100;
        global_irq_en <= 1'b1;
        // Stale low select must leave the synchroniser before master mode is armed
        repeat (6) @(posedge clk);
        wr(MSS_ADDR_CONTROL, 8'hd3);
        rd(MSS_ADDR_CONTROL, 8'hd3);
        tb_ss_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk({6'h00, pin_out.sck_oe, pin_out.mosi_oe}, 8'h00);
        chk({7'h00, irq}, 8'h01);
        rd(MSS_ADDR_CONTROL, 8'hc3);
        global_irq_en <= 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        global_irq_en <= 1'b1;
        irq_vector_taken <= 1'b1;
        @(posedge clk);
        irq_vector_taken <= 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        rd(MSS_ADDR_STATUS, 8'h00);
        tb_ss_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(MSS_ADDR_CONTROL, 8'hc3);
        pin_dir <= 5'b01000;
        wr(MSS_ADDR_CONTROL, 8'h40);
        wr(MSS_ADDR_DATA, 8'h5a);
        chk({7'h00, pin_out.miso_oe}, 8'h00);
        ext_frame(8'hc3, 8, 1'b1, got);
        chk(got, 8'h5a);
        poll(st);
        chk(st, 8'h80);
        rd(MSS_ADDR_DATA, 8'hc3);
        ext_frame(8'hff, 8, 1'b0, got);
        rd(MSS_ADDR_STATUS, 8'h00);
        ext_frame(8'h3c, 4, 1'b1, got);
        rd(MSS_ADDR_STATUS, 8'h00);
        ext_frame(8'h96, 8, 1'b1, got);
        poll(st);
        rd(MSS_ADDR_DATA, 8'h96);
        wrap_up();
    end
endmodule
`default_nettype wire
